//--- src/dsl_host.sv
// Purpose: Host end: APB registers drive 18-bit serial word transfers
// Assumes: Zero-wait APB slave; link clock made here by a divider
// Notes:   Illegal divide settings are refused and never sent
`timescale 1ns/1ps
module dsl_host #(
    parameter bit AUX_LOW_BAND = 1'b0
) (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    dsl_link_if.host link
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOW = 3'b001,
        ST_HIGH = 3'b010,
        ST_STROBE = 3'b011,
        ST_GAP = 3'b100
    } dsl_state_t;

    dsl_state_t state_r;
    logic [17:0] word_r;
    logic [17:0] shift_r;
    logic [4:0] bits_r;
    logic [3:0] tim_r;
    logic refused_r;
    logic [15:0] sent_r;
    logic sclk_r;
    logic sdata_r;
    logic le_r;
    logic wr;
    logic mapped;
    logic start;
    logic accept;
    logic half_done;

    function automatic logic word_legal(input logic [17:0] w);
        logic [11:0] b;
        logic [3:0] a;
        logic [16:0] n;
        b = w[dsl_pkg::PCNT_MSB:dsl_pkg::PCNT_LSB];
        a = w[dsl_pkg::SCNT_MSB:dsl_pkg::SCNT_LSB];
        if (AUX_LOW_BAND && w[1:0] == dsl_pkg::ADDR_AUX_FB) begin
            a = {1'b0, a[2:0]};
        end
        n = 17'(17'(b) * 17'(AUX_LOW_BAND ? dsl_pkg::MOD_AUX_LO :
            dsl_pkg::MOD_AUX_HI)) + 17'(a);
        word_legal = 1'b1;
        unique case (w[1:0])
            dsl_pkg::ADDR_AUX_REF, dsl_pkg::ADDR_MAIN_REF:
                word_legal = w[dsl_pkg::RCNT_MSB:dsl_pkg::RCNT_LSB] >=
                    dsl_pkg::REF_MIN;
            dsl_pkg::ADDR_AUX_FB:
                word_legal = (b >= dsl_pkg::PROG_MIN) && ({8'h00, b} >=
                    {8'h00, 8'h00, a}) && (n >= (AUX_LOW_BAND ?
                    dsl_pkg::AUX_N_MIN_LO : dsl_pkg::AUX_N_MIN_HI)) &&
                    (n <= (AUX_LOW_BAND ? dsl_pkg::AUX_N_MAX_LO :
                    dsl_pkg::AUX_N_MAX_HI));
            dsl_pkg::ADDR_MAIN_FB:
                word_legal = (b >= dsl_pkg::PROG_MIN) &&
                    (b >= {8'h00, a});
        endcase
    endfunction

    // Bus decode; zero-wait slave
    assign wr = psel && penable && pwrite;
    assign mapped = (paddr == dsl_pkg::OFS_WORD) ||
        (paddr == dsl_pkg::OFS_CTRL) || (paddr == dsl_pkg::OFS_STATUS) ||
        (paddr == dsl_pkg::OFS_SENT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign start = wr && paddr == dsl_pkg::OFS_CTRL &&
        pwdata[dsl_pkg::CTRL_START];
    assign accept = start && state_r == ST_IDLE && word_legal(word_r);
    assign half_done = (tim_r == 4'(dsl_pkg::SCLK_HALF - 4'h1));

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            unique case (paddr)
                dsl_pkg::OFS_WORD: prdata <= {14'h0000, word_r};
                dsl_pkg::OFS_STATUS: prdata <= {30'h00000000, refused_r,
                    state_r != ST_IDLE};
                dsl_pkg::OFS_SENT: prdata <= {16'h0000, sent_r};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Word register, written any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_r <= dsl_pkg::LATCH_RST;
        end else if (wr && paddr == dsl_pkg::OFS_WORD) begin
            word_r <= pwdata[17:0];
        end
    end

    // Refused flag: set beats write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_r <= 1'b0;
        end else if (start && !accept) begin
            refused_r <= 1'b1;
        end else if (wr && paddr == dsl_pkg::OFS_STATUS &&
                     pwdata[dsl_pkg::STAT_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // Half-period timer of the serial clock divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tim_r <= 4'h0;
        end else if (state_r == ST_IDLE || half_done) begin
            tim_r <= 4'h0;
        end else begin
            tim_r <= 4'(tim_r + 4'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            shift_r <= dsl_pkg::LATCH_RST;
            bits_r <= 5'h00;
            sent_r <= 16'h0000;
        end else begin
            unique case (state_r)
                ST_IDLE: if (accept) begin
                    state_r <= ST_LOW;
                    shift_r <= word_r;
                    bits_r <= 5'(dsl_pkg::WORD_W);
                end
                ST_LOW: if (half_done) begin
                    state_r <= ST_HIGH;
                end
                ST_HIGH: if (half_done) begin
                    shift_r <= {shift_r[16:0], 1'b0};
                    bits_r <= 5'(bits_r - 5'h01);
                    state_r <= (bits_r == 5'h01) ? ST_STROBE : ST_LOW;
                end
                ST_STROBE: if (half_done) begin
                    state_r <= ST_GAP;
                    sent_r <= 16'(sent_r + 16'h0001);
                end
                ST_GAP: if (half_done) begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_r <= 1'b0;
            sdata_r <= 1'b0;
            le_r <= 1'b0;
        end else begin
            sclk_r <= (state_r == ST_LOW && half_done) ||
                (state_r == ST_HIGH && !half_done);
            sdata_r <= (state_r == ST_LOW || state_r == ST_HIGH) ?
                shift_r[17] : 1'b0;
            le_r <= (state_r == ST_HIGH && half_done && bits_r == 5'h01) ||
                (state_r == ST_STROBE && !half_done);
        end
    end

    assign link.sclk = sclk_r;
    assign link.sdata = sdata_r;
    assign link.latch_strobe = le_r;
endmodule

//--- src/dsl_pkg.sv
// Purpose: Shared constants for the dual synthesizer serial latch link
// Assumes: 18-bit words, two address bits at the bottom, MSB first
// Notes:   Host register offsets are byte addresses on APB
package dsl_pkg;
    // Word layout
    localparam int WORD_W = 18;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 2;
    localparam int DATA_LSB = 2;
    // Latch address codes
    localparam logic [1:0] ADDR_AUX_REF = 2'h0;
    localparam logic [1:0] ADDR_AUX_FB = 2'h1;
    localparam logic [1:0] ADDR_MAIN_REF = 2'h2;
    localparam logic [1:0] ADDR_MAIN_FB = 2'h3;
    // Field positions inside the 18-bit word
    localparam int TOP_MSB = 17;
    localparam int TOP_LSB = 14;
    localparam int RCNT_MSB = 13;
    localparam int RCNT_LSB = 2;
    localparam int PCNT_MSB = 17;
    localparam int PCNT_LSB = 6;
    localparam int SCNT_MSB = 5;
    localparam int SCNT_LSB = 2;
    localparam int AUX_GAIN_BIT = 17;
    localparam int MAIN_GAIN_BIT = 16;
    localparam int AUX_POL_BIT = 15;
    localparam int MAIN_POL_BIT = 14;
    // Latch reset value
    localparam logic [17:0] LATCH_RST = 18'h00000;
    // Prescaler moduli
    localparam logic [5:0] MOD_REF = 6'h01;
    localparam logic [5:0] MOD_AUX_HI = 6'h10;
    localparam logic [5:0] MOD_AUX_LO = 6'h08;
    localparam logic [5:0] MOD_MAIN = 6'h10;
    // Legal ranges
    localparam logic [11:0] REF_MIN = 12'h002;
    localparam logic [11:0] PROG_MIN = 12'h003;
    localparam logic [16:0] AUX_N_MIN_HI = 17'h000F0;
    localparam logic [16:0] AUX_N_MIN_LO = 17'h00038;
    localparam logic [16:0] AUX_N_MAX_HI = 17'h0FFFF;
    localparam logic [16:0] AUX_N_MAX_LO = 17'h07FFF;
    // Link timing: serial clock period and derived half period in pclk
    localparam int PCLK_NS = 25;
    localparam int SCLK_PERIOD_NS = 200;
    localparam logic [3:0] SCLK_HALF =
        4'((SCLK_PERIOD_NS / 2 + PCLK_NS - 1) / PCLK_NS);
    // Host APB register offsets
    localparam logic [7:0] OFS_WORD = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SENT = 8'h0C;
    localparam int CTRL_START = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_REFUSED = 1;
endpackage

//--- src/dsl_link_if.sv
// Purpose: Three-wire serial programming link between host and device
// Assumes: Host drives all three lines, device only listens
// Notes:   No clocking block; ends sample with their own pclk
`timescale 1ns/1ps
interface dsl_link_if;
    logic sclk;
    logic sdata;
    logic latch_strobe;
    modport host (output sclk, output sdata, output latch_strobe);
    modport dev (input sclk, input sdata, input latch_strobe);
endinterface

//--- src/dsl_div_counter.sv
// Purpose: Dual-modulus pulse-swallow divider, also used as plain divider
// Assumes: tick is a one-cycle pulse per input period on pclk
// Notes:   Ratio is modulus*prog+swallow; modulus 1, swallow 0 gives R
`timescale 1ns/1ps
module dsl_div_counter (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Input events and setting
    input wire logic tick,
    input wire logic [11:0] prog_count,
    input wire logic [3:0] swallow_count,
    input wire logic [5:0] modulus,
    // Output
    output logic div_pulse
);
    logic [5:0] pre_r;
    logic [11:0] prg_r;
    logic [3:0] swl_r;
    logic [5:0] per_len;
    logic per_end;
    logic term;

    // Period length is modulus plus one while swallowing
    assign per_len = (swl_r != 4'h0) ? 6'(modulus + 6'h01) : modulus;
    assign per_end = tick && (6'(pre_r + 6'h01) >= per_len);
    assign term = (prg_r <= 12'h001);

    // Prescaler phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 6'h00;
        end else if (per_end) begin
            pre_r <= 6'h00;
        end else if (tick) begin
            pre_r <= 6'(pre_r + 6'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prg_r <= 12'h000;
            swl_r <= 4'h0;
        end else if (per_end) begin
            if (term) begin
                prg_r <= prog_count;
                swl_r <= swallow_count;
            end else begin
                prg_r <= 12'(prg_r - 12'h001);
                if (swl_r != 4'h0) begin
                    swl_r <= 4'(swl_r - 4'h1);
                end
            end
        end
    end

    // One pulse per full division
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_pulse <= 1'b0;
        end else begin
            div_pulse <= per_end && term;
        end
    end
endmodule

//--- src/dsl_device.sv
// Purpose: Device end: serial shift register, four latches, dividers
// Assumes: Link lines and frequency inputs are asynchronous to pclk
// Notes:   Every external level passes two flops before use
// Behaviour
// - 18-bit shift register, 16 payload, 2 address
// - Words move MSB first, address last
// - Data sampled on serial clock rising edge
// - Strobe rise copies payload into one latch
// - Address 00,01,10,11 pick AuxR,AuxN,MainR,MainN
// - Aux reference: output select plus divide
// - Reference divide values binary, 2 to 4095
// - Main reference: pump word plus divide
// - Pump word sets gains and polarities
// - Bits 17..14: gains then polarities
// - Aux feedback: program count then swallow
// - Host keeps Aux ratio inside band range
// - Low band ignores swallow bit three
// - Host keeps program count 3 to 4095
// - Host keeps program count at or above swallow
// - Divide by P+1 A times, then P
`timescale 1ns/1ps
module dsl_device #(
    parameter bit AUX_LOW_BAND = 1'b0
) (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Serial link
    dsl_link_if.dev link,
    // Frequency inputs
    input wire logic osc_in,
    input wire logic aux_fin,
    input wire logic main_fin,
    // Latch contents
    output logic [15:0] aux_ref_latch,
    output logic [15:0] aux_fb_latch,
    output logic [15:0] main_ref_latch,
    output logic [15:0] main_fb_latch,
    // Decoded controls
    output logic [3:0] multifunction_output_select,
    output logic [3:0] pump_control_word,
    output logic aux_pump_gain_select,
    output logic main_pump_gain_select,
    output logic aux_detector_polarity,
    output logic main_detector_polarity,
    // Divider outputs
    output logic aux_ref_pulse,
    output logic aux_fb_pulse,
    output logic main_ref_pulse,
    output logic main_fb_pulse
);
    // Synchroniser bit positions
    localparam int SY_SCLK = 0;
    localparam int SY_DATA = 1;
    localparam int SY_LE = 2;
    localparam int SY_OSC = 3;
    localparam int SY_AUX = 4;
    localparam int SY_MAIN = 5;

    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic [5:0] prev_r;
    logic [5:0] rise;
    logic [17:0] shift_r;
    logic [1:0] latch_address_bits;
    logic [15:0] payload;
    logic [15:0] aux_ref_r;
    logic [15:0] aux_fb_r;
    logic [15:0] main_ref_r;
    logic [15:0] main_fb_r;
    logic [3:0] aux_swallow_count;
    logic [11:0] aux_program_count;
    logic [3:0] main_swallow_count;
    logic [11:0] main_program_count;
    logic [11:0] aux_reference_count;
    logic [11:0] main_reference_count;
    logic [5:0] aux_mod;

    // Two-flop synchronisers for link and frequency inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end else begin
            meta_r <= {main_fin, aux_fin, osc_in,
                       link.latch_strobe, link.sdata, link.sclk};
            sync_r <= meta_r;
        end
    end

    // Previous synchronised levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 6'h00;
        end else begin
            prev_r <= sync_r;
        end
    end

    // Rising edges of every synchronised input
    assign rise = sync_r & ~prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= dsl_pkg::LATCH_RST;
        end else if (rise[SY_SCLK]) begin
            shift_r <= {shift_r[16:0], sync_r[SY_DATA]};
        end
    end

    assign latch_address_bits = shift_r[dsl_pkg::ADDR_W-1:0];
    assign payload = shift_r[dsl_pkg::WORD_W-1:dsl_pkg::DATA_LSB];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_ref_r <= 16'h0000;
            aux_fb_r <= 16'h0000;
            main_ref_r <= 16'h0000;
            main_fb_r <= 16'h0000;
        end else if (rise[SY_LE]) begin
            unique case (latch_address_bits)
                dsl_pkg::ADDR_AUX_REF: aux_ref_r <= payload;
                dsl_pkg::ADDR_AUX_FB: aux_fb_r <= payload;
                dsl_pkg::ADDR_MAIN_REF: main_ref_r <= payload;
                dsl_pkg::ADDR_MAIN_FB: main_fb_r <= payload;
            endcase
        end
    end

    // Latch contents leave directly from the latch flops
    assign aux_ref_latch = aux_ref_r;
    assign aux_fb_latch = aux_fb_r;
    assign main_ref_latch = main_ref_r;
    assign main_fb_latch = main_fb_r;

    assign multifunction_output_select =
        aux_ref_r[dsl_pkg::TOP_MSB-2:dsl_pkg::TOP_LSB-2];
    assign aux_reference_count =
        aux_ref_r[dsl_pkg::RCNT_MSB-2:dsl_pkg::RCNT_LSB-2];

    assign pump_control_word =
        main_ref_r[dsl_pkg::TOP_MSB-2:dsl_pkg::TOP_LSB-2];
    assign main_reference_count =
        main_ref_r[dsl_pkg::RCNT_MSB-2:dsl_pkg::RCNT_LSB-2];

    assign aux_pump_gain_select = main_ref_r[dsl_pkg::AUX_GAIN_BIT-2];
    assign main_pump_gain_select = main_ref_r[dsl_pkg::MAIN_GAIN_BIT-2];
    assign aux_detector_polarity = main_ref_r[dsl_pkg::AUX_POL_BIT-2];
    assign main_detector_polarity = main_ref_r[dsl_pkg::MAIN_POL_BIT-2];

    assign aux_program_count =
        aux_fb_r[dsl_pkg::PCNT_MSB-2:dsl_pkg::PCNT_LSB-2];
    assign aux_swallow_count = AUX_LOW_BAND ?
        {1'b0, aux_fb_r[2:0]} :
        aux_fb_r[dsl_pkg::SCNT_MSB-2:dsl_pkg::SCNT_LSB-2];
    assign aux_mod = AUX_LOW_BAND ? dsl_pkg::MOD_AUX_LO :
        dsl_pkg::MOD_AUX_HI;

    // Main feedback uses the same 12/4 split as Aux
    assign main_program_count =
        main_fb_r[dsl_pkg::PCNT_MSB-2:dsl_pkg::PCNT_LSB-2];
    assign main_swallow_count =
        main_fb_r[dsl_pkg::SCNT_MSB-2:dsl_pkg::SCNT_LSB-2];

    dsl_div_counter u_aux_ref (
        .pclk(pclk),
        .presetn(presetn),
        .tick(rise[SY_OSC]),
        .prog_count(aux_reference_count),
        .swallow_count(4'h0),
        .modulus(dsl_pkg::MOD_REF),
        .div_pulse(aux_ref_pulse)
    );

    dsl_div_counter u_main_ref (
        .pclk(pclk),
        .presetn(presetn),
        .tick(rise[SY_OSC]),
        .prog_count(main_reference_count),
        .swallow_count(4'h0),
        .modulus(dsl_pkg::MOD_REF),
        .div_pulse(main_ref_pulse)
    );

    dsl_div_counter u_aux_fb (
        .pclk(pclk),
        .presetn(presetn),
        .tick(rise[SY_AUX]),
        .prog_count(aux_program_count),
        .swallow_count(aux_swallow_count),
        .modulus(aux_mod),
        .div_pulse(aux_fb_pulse)
    );

    dsl_div_counter u_main_fb (
        .pclk(pclk),
        .presetn(presetn),
        .tick(rise[SY_MAIN]),
        .prog_count(main_program_count),
        .swallow_count(main_swallow_count),
        .modulus(dsl_pkg::MOD_MAIN),
        .div_pulse(main_fb_pulse)
    );
endmodule

//--- tb/dsl_assertions.sv
// Purpose: Wire-level checks on the serial programming link
// Assumes: Link lines come from host flops clocked by pclk
// Notes:   Clock pulse count restarts with every strobe
`timescale 1ns/1ps
module dsl_assertions (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Link lines
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe
);
    logic sclk_d;
    logic [4:0] bits_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Previous serial clock level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk;
        end
    end
    // Clock pulses since the last strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_r <= 5'h00;
        end else if (latch_strobe) begin
            bits_r <= 5'h00;
        end else if (sclk && !sclk_d) begin
            bits_r <= bits_r + 5'h01;
        end
    end
    // Phases of one bit and of the strobe
    sequence high_phase;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence low_phase;
        !sclk [*4] ##1 sclk;
    endsequence
    sequence strobe_pulse;
        latch_strobe [*4] ##1 !latch_strobe [*4];
    endsequence
    clk_high_a: assert property ($rose(sclk) |-> high_phase)
        else $error("serial clock high phase wrong");
    clk_low_a: assert property
        ($fell(sclk) && !$rose(latch_strobe) |-> low_phase)
        else $error("serial clock low phase wrong");
    data_hold_a: assert property (sclk |-> $stable(sdata))
        else $error("data moved while clock high");
    data_setup_a: assert property
        ($rose(sclk) |-> $past(sdata, 2) == sdata)
        else $error("data not set up before clock rise");
    strobe_shape_a: assert property
        ($rose(latch_strobe) |-> strobe_pulse)
        else $error("strobe pulse or gap wrong");
    strobe_quiet_a: assert property (latch_strobe |-> !sclk)
        else $error("clock pulsed during strobe");
    word_bits_a: assert property
        ($rose(latch_strobe) |-> bits_r == 5'h12)
        else $error("strobe after wrong bit count");
    strobe_edge_a: assert property
        ($rose(latch_strobe) |-> $fell(sclk))
        else $error("strobe not with last clock fall");
endmodule

//--- tb/testbench.sv
// Purpose: Host and device joined by the link, driven over APB
// Assumes: Frequency inputs toggle with a 4 pclk period
// Notes:   Wire word captured on every serial clock rise
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic osc_in, aux_fin, main_fin;
    logic [15:0] arl, afl, mrl, mfl;
    logic [3:0] mfo, pcw, fin_cnt;
    logic ag, mg, ap, mp, arp, afp, mrp, mfp, afp_lo;
    logic [17:0] cap;
    int nbits, n_mismatch, num_checks, cyc;
    dsl_link_if link();
    dsl_host u_dsl_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    dsl_device u_dsl_device (.pclk(pclk), .presetn(presetn),
        .link(link), .osc_in(osc_in), .aux_fin(aux_fin),
        .main_fin(main_fin), .aux_ref_latch(arl), .aux_fb_latch(afl),
        .main_ref_latch(mrl), .main_fb_latch(mfl),
        .multifunction_output_select(mfo), .pump_control_word(pcw),
        .aux_pump_gain_select(ag), .main_pump_gain_select(mg),
        .aux_detector_polarity(ap), .main_detector_polarity(mp),
        .aux_ref_pulse(arp), .aux_fb_pulse(afp),
        .main_ref_pulse(mrp), .main_fb_pulse(mfp));
    // low band listener on the same link
    dsl_device #(.AUX_LOW_BAND(1'b1)) u_dsl_device_lo (.pclk(pclk),
        .presetn(presetn), .link(link), .osc_in(osc_in),
        .aux_fin(aux_fin), .main_fin(main_fin), .aux_ref_latch(),
        .aux_fb_latch(), .main_ref_latch(), .main_fb_latch(),
        .multifunction_output_select(), .pump_control_word(),
        .aux_pump_gain_select(), .main_pump_gain_select(),
        .aux_detector_polarity(), .main_detector_polarity(),
        .aux_ref_pulse(), .aux_fb_pulse(afp_lo),
        .main_ref_pulse(), .main_fb_pulse());
    dsl_assertions u_dsl_assertions (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .sdata(link.sdata),
        .latch_strobe(link.latch_strobe));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Frequency inputs and timeout
    always @(posedge pclk) begin
        fin_cnt <= fin_cnt + 4'h1;
        osc_in <= fin_cnt[1];
        aux_fin <= fin_cnt[1];
        main_fin <= fin_cnt[1];
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // Word seen on the wire
    always @(posedge link.sclk) begin
        cap <= {cap[16:0], link.sdata};
        nbits <= nbits + 1;
    end
    task report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, string m);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // One APB transfer; read data in rd, error in err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Send one word and wait until the host is idle
    task send(input logic [17:0] w);
        int i;
        nbits = 0;
        i = 0;
        apb(1'b1, dsl_pkg::OFS_WORD, {14'h0000, w});
        apb(1'b1, dsl_pkg::OFS_CTRL, 32'h00000001);
        do begin
            apb(1'b0, dsl_pkg::OFS_STATUS, 32'h0);
            i++;
        end while (rd[dsl_pkg::STAT_BUSY] !== 1'b0 && i < 500);
        chk(nbits, 18, "bit count on wire");
        chk(cap, w, "word on wire");
    endtask
    // Each address code fills its own latch only
    task t_latches;
        logic [15:0] pay [4];
        logic [15:0] ex [4];
        pay = '{16'hA002, 16'h00F0, 16'h9FFF, 16'h00F1};
        ex = '{default: 16'h0000};
        for (int i = 0; i < 4; i++) begin
            send({pay[i], 2'(i)});
            ex[i] = pay[i];
            chk(arl, ex[0], "aux ref latch");
            chk(afl, ex[1], "aux feedback latch");
            chk(mrl, ex[2], "main ref latch");
            chk(mfl, ex[3], "main feedback latch");
        end
        chk(mfo, 4'hA, "output select");
        chk(pcw, 4'h9, "pump word");
        chk({ag, mg, ap, mp}, 4'h9, "gain and polarity bits");
    endtask
    // Registers, unmapped place, words sent
    task t_regs;
        apb(1'b1, dsl_pkg::OFS_WORD, 32'hFFFFFFFF);
        apb(1'b0, dsl_pkg::OFS_WORD, 32'h0);
        chk(rd, 32'h0003FFFF, "word readback");
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped access");
        apb(1'b0, dsl_pkg::OFS_SENT, 32'h0);
        chk(rd, 32'h00000004, "sent count");
    endtask
    // Illegal divide settings never reach the wire
    task t_refuse;
        logic [17:0] bad [4];
        bad = '{18'h00004, 18'h00081, 18'h000D1, 18'h00381};
        foreach (bad[i]) begin
            nbits = 0;
            apb(1'b1, dsl_pkg::OFS_WORD, {14'h0000, bad[i]});
            apb(1'b1, dsl_pkg::OFS_CTRL, 32'h00000001);
            apb(1'b0, dsl_pkg::OFS_STATUS, 32'h0);
            chk(rd[1:0], 2'b10, "illegal word accepted");
            apb(1'b1, dsl_pkg::OFS_STATUS, 32'h00000002);
            apb(1'b0, dsl_pkg::OFS_STATUS, 32'h0);
            chk(rd[1:0], 2'b00, "refused flag not cleared");
            chk(nbits, 0, "illegal word shifted");
        end
        chk(afl, 16'h00F0, "latch changed by refusal");
        chk(arl, 16'hA002, "ref latch changed");
    endtask
    function logic pick(input int s);
        case (s)
            0: return arp;
            1, 4: return afp;
            2: return mrp;
            5: return afp_lo;
            default: return mfp;
        endcase
    endfunction
    // Period of each divider output in pclk; swallow bit three last
    task t_div;
        int exp [6];
        int n;
        exp = '{8, 960, 16380, 964, 992, 480};
        for (int s = 0; s < 6; s++) begin
            if (s == 4) begin
                send({16'h00F8, dsl_pkg::ADDR_AUX_FB});
            end
            @(posedge pclk);
            while (pick(s) !== 1'b1) @(posedge pclk);
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pick(s) !== 1'b1 && n < 20000);
            chk(n, exp[s], "divider period");
        end
    endtask
    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, err} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {osc_in, aux_fin, main_fin} = 3'h0;
        fin_cnt = 4'h0;
        cap = 18'h00000;
        {nbits, n_mismatch, num_checks, cyc} = 128'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_latches();
        t_regs();
        t_refuse();
        t_div();
        report_and_stop();
    end
endmodule
